// ==== rtl/sdram_pkg.sv ====
// Purpose: shared constants for the sdram device end and controller end
// Assumes: one clock, pclk at 25 MHz
// Notes: times are kept in ns, cycle counts derive from them, except MODE_GAP_CYC and DQM_LEAD_CYC
package sdram_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int CLK_MHZ = 25;
  localparam int LAT2_MAX_MHZ = 133;
  localparam int LAT3_MAX_MHZ = 143;
  localparam int ACT_TO_COL_NS = 20;
  localparam int SAME_BANK_ACT_NS = 70;
  localparam int CROSS_BANK_ACT_NS = 14;
  localparam int PRECHARGE_NS = 20;
  localparam int ACT_TO_COL_CYC = (ACT_TO_COL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAME_BANK_ACT_CYC = (SAME_BANK_ACT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CROSS_BANK_ACT_CYC = (CROSS_BANK_ACT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRECHARGE_CYC = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MODE_GAP_CYC = 2;
  localparam int DQM_LEAD_CYC = 3;
  // mode word layout
  localparam int MODE_W = 10;
  localparam int BURST_LENGTH_LSB = 0;
  localparam int BURST_TYPE_BIT = 3;
  localparam int READ_LATENCY_LSB = 4;
  localparam int OPERATING_MODE_LOW = 7;
  localparam int OPERATING_MODE_HIGH = 8;
  localparam int WRITE_BURST_MODE_BIT = 9;
  localparam logic [MODE_W-1:0] MODE_RESET = 10'h020;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] LAT_2 = 3'h2;
  localparam logic [2:0] LAT_3 = 3'h3;
  localparam int AUTO_PRE_BIT = 10;
  localparam int COL_BITS = 8;
  // {ras_n, cas_n, we_n} with chip select low
  localparam logic [2:0] PIN_MODE = 3'h0;
  localparam logic [2:0] PIN_ACT = 3'h3;
  localparam logic [2:0] PIN_READ = 3'h5;
  localparam logic [2:0] PIN_WRITE = 3'h4;
  localparam logic [2:0] PIN_PRE = 3'h2;
  localparam logic [2:0] PIN_TERM = 3'h6;
  localparam logic [2:0] PIN_NOP = 3'h7;
  // controller registers, byte addresses
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_MODE = 8'h14;
  localparam logic [2:0] OP_MODE = 3'h0;
  localparam logic [2:0] OP_ACT = 3'h1;
  localparam logic [2:0] OP_READ = 3'h2;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_PRE = 3'h4;
  localparam int BANK_LSB = 12;
endpackage

// ==== rtl/sdram_link_if.sv ====
// Purpose: pins between the memory controller and the sdram device
// Assumes: both ends clocked by the same pclk
// Notes: dq_level resolves the shared data pins from the enables
`timescale 1ns/1ps
interface sdram_link_if;
  logic chip_select_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic bank_select_low;
  logic bank_select_high;
  logic [11:0] address_pins;
  logic [1:0] byte_mask;
  logic [15:0] ctrl_dq_out;
  logic ctrl_dq_oe;
  logic [15:0] mem_dq_out;
  logic [1:0] mem_dq_oe;
  logic [15:0] dq_level;
  // undriven lanes read as zero
  always_comb begin
    dq_level = ctrl_dq_oe ? ctrl_dq_out : 16'h0000;
    if (mem_dq_oe[0]) dq_level[7:0] = mem_dq_out[7:0];
    if (mem_dq_oe[1]) dq_level[15:8] = mem_dq_out[15:8];
  end
  modport memory_end (
    input chip_select_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high,
    input address_pins, byte_mask, dq_level,
    output mem_dq_out, mem_dq_oe
  );
  modport controller_end (
    output chip_select_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high,
    output address_pins, byte_mask, ctrl_dq_out, ctrl_dq_oe,
    input dq_level
  );
endinterface

// ==== rtl/sdram_device_end.sv ====
// Purpose: four-bank sdram read path, row activation and mode handling
// Assumes: commands sampled on rising pclk; small backing store
// Notes: write bursts kept minimal, enough to fill data for reads
`timescale 1ns/1ps
module sdram_device_end
  import sdram_pkg::*;
#(
  parameter int MEM_ROW_BITS = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link pins
  sdram_link_if.memory_end link,
  // status
  output logic [3:0] banks_open
);
  localparam int IDX_W = 2 + MEM_ROW_BITS + COL_BITS;

  typedef struct packed {
    logic [MODE_W-1:0] mode;
    logic [3:0] open;
    logic [3:0][11:0] row;
    logic busy;
    logic is_write;
    logic auto_pre;
    logic [1:0] bank;
    logic [COL_BITS-1:0] start;
    logic [COL_BITS-1:0] idx;
    logic p1_valid;
    logic [15:0] p1_data;
    logic [1:0] mask_d;
    logic [15:0] dq_out;
    logic [1:0] dq_oe;
  } mem_state_type;

  mem_state_type s;
  mem_state_type next_s;
  logic [15:0] store [1 << IDX_W];
  logic mem_we;
  logic [1:0] mem_be;
  logic [IDX_W-1:0] mem_idx;
  logic [15:0] mem_wdata;

  function automatic logic [COL_BITS-1:0] burst_mask(input logic [2:0] code);
    logic [8:0] one_hot;
    one_hot = 9'h001 << code;
    burst_mask = (code == BL_PAGE) ? 8'hFF : 8'(one_hot - 9'h001);
  endfunction

  function automatic logic [COL_BITS-1:0] elem_col(input logic [COL_BITS-1:0] start,
      input logic [COL_BITS-1:0] idx, input logic [COL_BITS-1:0] mask, input logic inter);
    logic [COL_BITS-1:0] low;
    low = inter ? (start ^ idx) : 8'(start + idx);
    elem_col = (start & ~mask) | (low & mask);
  endfunction

  always_comb begin
    logic [2:0] pins;
    logic is_mode;
    logic is_act;
    logic is_read;
    logic is_write;
    logic is_pre;
    logic is_term;
    logic [1:0] bank_in;
    logic [COL_BITS-1:0] mask;
    logic page;
    logic lat3;
    logic inter;
    logic last;
    logic emit_rd;
    logic emit_wr;
    logic [15:0] rd_word;
    logic [COL_BITS-1:0] cur_col;
    next_s = s;
    pins = {link.ras_n, link.cas_n, link.we_n};
    is_mode = !link.chip_select_n && pins == PIN_MODE;
    is_act = !link.chip_select_n && pins == PIN_ACT;
    is_read = !link.chip_select_n && pins == PIN_READ;
    is_write = !link.chip_select_n && pins == PIN_WRITE;
    is_pre = !link.chip_select_n && pins == PIN_PRE;
    is_term = !link.chip_select_n && pins == PIN_TERM;
    bank_in = {link.bank_select_high, link.bank_select_low};
    mask = burst_mask(s.mode[BURST_LENGTH_LSB +: 3]);
    page = s.mode[BURST_LENGTH_LSB +: 3] == BL_PAGE;
    lat3 = s.mode[READ_LATENCY_LSB +: 3] == LAT_3;
    inter = s.mode[BURST_TYPE_BIT] && !page;
    cur_col = elem_col(s.start, s.idx, mask, inter);
    last = !page && s.idx == mask;
    emit_rd = s.busy && !s.is_write && !is_write;
    emit_wr = s.busy && s.is_write && !(is_read || is_write || is_pre || is_term || is_mode);
    rd_word = store[{s.bank, s.row[s.bank][MEM_ROW_BITS-1:0], cur_col}];
    mem_we = emit_wr;
    mem_be = ~link.byte_mask;
    mem_idx = {s.bank, s.row[s.bank][MEM_ROW_BITS-1:0], cur_col};
    mem_wdata = link.dq_level;
    next_s.mask_d = link.byte_mask;
    next_s.p1_valid = emit_rd;
    next_s.p1_data = rd_word;
    // output set one edge before valid
    next_s.dq_out = lat3 ? s.p1_data : rd_word;
    next_s.dq_oe = (lat3 ? s.p1_valid : emit_rd) ? ~s.mask_d : 2'b00;
    if (s.busy) begin
      if (last) begin
        next_s.busy = 1'b0;
        if (s.auto_pre) next_s.open[s.bank] = 1'b0;
      end else begin
        next_s.idx = 8'(s.idx + 8'h01);
      end
    end
    if (is_mode) next_s.mode = link.address_pins[MODE_W-1:0];
    if (is_act) begin
      next_s.open[bank_in] = 1'b1;
      next_s.row[bank_in] = link.address_pins;
    end
    if (is_read) begin
      next_s.busy = 1'b1;
      next_s.is_write = 1'b0;
      next_s.bank = bank_in;
      next_s.start = link.address_pins[COL_BITS-1:0];
      next_s.idx = '0;
      next_s.auto_pre = link.address_pins[AUTO_PRE_BIT];
    end
    if (is_write) begin
      next_s.p1_valid = 1'b0;
      next_s.dq_oe = 2'b00;
      mem_we = 1'b1;
      mem_idx = {bank_in, s.row[bank_in][MEM_ROW_BITS-1:0], link.address_pins[COL_BITS-1:0]};
      next_s.bank = bank_in;
      next_s.start = link.address_pins[COL_BITS-1:0];
      next_s.idx = 8'h01;
      next_s.is_write = 1'b1;
      next_s.auto_pre = link.address_pins[AUTO_PRE_BIT];
      next_s.busy = !(s.mode[WRITE_BURST_MODE_BIT] || (mask == 8'h00 && !page));
      if (!next_s.busy && link.address_pins[AUTO_PRE_BIT]) next_s.open[bank_in] = 1'b0;
    end
    if (is_term) next_s.busy = 1'b0;
    if (is_pre) begin
      if (link.address_pins[AUTO_PRE_BIT]) begin
        next_s.open = '0;
        next_s.busy = 1'b0;
      end else begin
        next_s.open[bank_in] = 1'b0;
        if (s.bank == bank_in) next_s.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.mode <= MODE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // store has no reset: contents are undefined after power-up anyway
  always_ff @(posedge pclk) begin
    if (mem_we && mem_be[0]) store[mem_idx][7:0] <= mem_wdata[7:0];
    if (mem_we && mem_be[1]) store[mem_idx][15:8] <= mem_wdata[15:8];
  end

  assign link.mem_dq_out = s.dq_out;
  assign link.mem_dq_oe = s.dq_oe;
  assign banks_open = s.open;
endmodule

// ==== rtl/sdram_controller_end.sv ====
// Purpose: apb-driven command sequencer facing the sdram pins
// Assumes: one operation at a time, single-word reads and writes
// Notes: spacing counts derive from the ns figures in the package, except the mode gap and the mask lead
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module sdram_controller_end
  import sdram_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link pins
  sdram_link_if.controller_end link
);
  typedef enum logic [2:0] {C_IDLE, C_GUARD, C_ISSUE, C_FOLLOW, C_WAIT} ctl_state_type;

  typedef struct packed {
    ctl_state_type state;
    logic [2:0] op;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [MODE_W-1:0] mode;
    logic err;
    logic reading;
    logic [7:0] cnt;
    logic [7:0] since_act;
    logic [1:0] act_bank;
    logic [3:0] pins;
    logic [1:0] bank;
    logic [11:0] apins;
    logic [1:0] dqm;
    logic [15:0] dq_out;
    logic dq_oe;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ctl_state_record_type;

  ctl_state_record_type s;
  ctl_state_record_type next_s;

  always_comb begin
    logic access;
    logic [2:0] lat;
    logic [1:0] bank;
    logic [7:0] need;
    next_s = s;
    access = psel && penable && !s.pready;
    lat = s.mode[READ_LATENCY_LSB +: 3];
    bank = s.addr[BANK_LSB +: 2];
    need = (bank == s.act_bank) ? 8'(SAME_BANK_ACT_CYC) : 8'(CROSS_BANK_ACT_CYC);
    next_s.pready = access;
    next_s.pslverr = 1'b0;
    next_s.pins = {1'b1, PIN_NOP};
    next_s.dq_oe = 1'b0;
    next_s.dqm = 2'b00;
    if (s.since_act != 8'hFF) next_s.since_act = 8'(s.since_act + 8'h01);
    case (s.state)
      C_GUARD: begin
        next_s.dqm = 2'b11;
        next_s.cnt = 8'(s.cnt - 8'h01);
        if (s.cnt <= 8'h01) next_s.state = C_ISSUE;
      end
      C_ISSUE: begin
        next_s.bank = bank;
        next_s.apins = s.addr[11:0];
        next_s.state = C_WAIT;
        case (s.op)
          OP_MODE: begin
            if (s.addr[OPERATING_MODE_HIGH:OPERATING_MODE_LOW] != 2'b00 ||
                !((s.addr[READ_LATENCY_LSB +: 3] == LAT_2 && CLK_MHZ <= LAT2_MAX_MHZ) ||
                  (s.addr[READ_LATENCY_LSB +: 3] == LAT_3 && CLK_MHZ <= LAT3_MAX_MHZ))) begin
              next_s.err = 1'b1;
              next_s.state = C_IDLE;
            end else begin
              next_s.pins = {1'b0, PIN_MODE};
              next_s.mode = s.addr[MODE_W-1:0];
              next_s.cnt = 8'(MODE_GAP_CYC);
            end
          end
          OP_ACT: begin
            if (s.since_act < 8'(need - 8'h01)) begin
              next_s.state = C_ISSUE;
            end else begin
              next_s.pins = {1'b0, PIN_ACT};
              next_s.since_act = '0;
              next_s.act_bank = bank;
              next_s.cnt = 8'(ACT_TO_COL_CYC);
            end
          end
          OP_READ: begin
            next_s.pins = {1'b0, PIN_READ};
            next_s.reading = 1'b1;
            next_s.cnt = 8'({5'h00, lat} + 8'h01);
            if (!s.addr[AUTO_PRE_BIT]) next_s.state = C_FOLLOW;
          end
          OP_WRITE: begin
            next_s.pins = {1'b0, PIN_WRITE};
            next_s.dq_out = s.wdata;
            next_s.dq_oe = 1'b1;
            next_s.cnt = 8'h01;
            next_s.state = C_FOLLOW;
          end
          OP_PRE: begin
            next_s.pins = {1'b0, PIN_PRE};
            next_s.cnt = 8'(PRECHARGE_CYC);
          end
          default: begin
            next_s.err = 1'b1;
            next_s.state = C_IDLE;
          end
        endcase
      end
      C_FOLLOW: begin
        next_s.pins = {1'b0, PIN_TERM};
        next_s.cnt = 8'(s.cnt - 8'h01);
        next_s.state = C_WAIT;
      end
      C_WAIT: begin
        if (s.reading && s.cnt == 8'h01) begin
          next_s.rdata = link.dq_level;
          next_s.reading = 1'b0;
        end
        next_s.cnt = 8'(s.cnt - 8'h01);
        // return to idle leaves a gap
        if (s.cnt <= 8'h01) next_s.state = C_IDLE;
      end
      default: next_s.state = C_IDLE;
    endcase
    next_s.prdata = '0;
    if (access) begin
      case (paddr[7:0])
        REG_CMD: begin
          next_s.prdata = {29'h0, s.op};
          if (pwrite && s.state == C_IDLE) begin
            next_s.op = pwdata[2:0];
            next_s.state = (pwdata[2:0] == OP_WRITE) ? C_GUARD : C_ISSUE;
            next_s.cnt = 8'(DQM_LEAD_CYC);
            if (pwdata[2:0] == OP_WRITE) next_s.dqm = 2'b11;
          end else if (pwrite) begin
            next_s.err = 1'b1;
          end
        end
        REG_ADDR: begin
          next_s.prdata = {16'h0, s.addr};
          if (pwrite) next_s.addr = pwdata[15:0];
        end
        REG_WDATA: begin
          next_s.prdata = {16'h0, s.wdata};
          if (pwrite) next_s.wdata = pwdata[15:0];
        end
        REG_RDATA: next_s.prdata = {16'h0, s.rdata};
        REG_STATUS: begin
          next_s.prdata = {30'h0, s.err, s.state != C_IDLE};
          // a refusal in this same cycle keeps the error set
          if (pwrite && pwdata[1] && !(s.state == C_ISSUE && next_s.state == C_IDLE))
            next_s.err = 1'b0;
        end
        REG_MODE: next_s.prdata = {22'h0, s.mode};
        default: next_s.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.state <= C_IDLE;
      s.mode <= MODE_RESET;
      s.since_act <= 8'hFF;
      s.pins <= {1'b1, PIN_NOP};
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign {link.chip_select_n, link.ras_n, link.cas_n, link.we_n} = s.pins;
  assign {link.bank_select_high, link.bank_select_low} = s.bank;
  assign link.address_pins = s.apins;
  assign link.byte_mask = s.dqm;
  assign link.ctrl_dq_out = s.dq_out;
  assign link.ctrl_dq_oe = s.dq_oe;
endmodule

// ==== tb/sdram_link_asserts.sv ====
// Purpose: watches the pins between the controller end and the device end
// Assumes: one pclk domain; read latency follows the last mode command
// Notes: auto-precharge reads close their bank at the command here, a little early
`timescale 1ns/1ps
module sdram_link_asserts
  import sdram_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // command pins
  input wire logic chip_select_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic [11:0] address_pins,
  // data side
  input wire logic [1:0] byte_mask,
  input wire logic [1:0] mem_dq_oe
);
  wire logic [2:0] cmd = {ras_n, cas_n, we_n};
  wire logic [1:0] bank = {bank_select_high, bank_select_low};
  wire logic rd = !chip_select_n && cmd == PIN_READ;
  wire logic wr = !chip_select_n && cmd == PIN_WRITE;
  wire logic trm = !chip_select_n && cmd == PIN_TERM;
  wire logic act = !chip_select_n && cmd == PIN_ACT;
  wire logic md = !chip_select_n && cmd == PIN_MODE;
  logic [2:0] lat;
  logic [2:0] bl;
  logic [3:0] open_banks;

  // refused mode words never reach the pins, so the latency field is trusted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat <= LAT_2;
      bl <= 3'h0;
      open_banks <= 4'h0;
    end else if (md) begin
      lat <= address_pins[6:4];
      bl <= address_pins[2:0];
    end else if (act) begin
      open_banks[bank] <= 1'b1;
    end else if (!chip_select_n && cmd == PIN_PRE) begin
      if (address_pins[AUTO_PRE_BIT]) open_banks <= 4'h0;
      else open_banks[bank] <= 1'b0;
    end else if (rd && address_pins[AUTO_PRE_BIT]) begin
      open_banks[bank] <= 1'b0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_first_lat2: assert property (
    rd && lat == LAT_2 && byte_mask == 2'b00 |-> ##2 mem_dq_oe == 2'b11)
    else $error("no read data two clocks after read");
  a_first_lat3: assert property (
    rd && lat == LAT_3 ##1 byte_mask == 2'b00 |-> ##2 mem_dq_oe == 2'b11)
    else $error("no read data three clocks after read");
  a_quiet_before: assert property (
    rd && mem_dq_oe == 2'b00 |=> mem_dq_oe == 2'b00)
    else $error("data pins driven too early");
  a_quiet_lat3: assert property (
    rd && lat == LAT_3 && mem_dq_oe == 2'b00 |=> (mem_dq_oe == 2'b00) [*2])
    else $error("data pins driven too early at latency three");
  a_term_lat2: assert property (
    trm && lat == LAT_2 && $past(rd) |-> ##1 mem_dq_oe == 2'b11 ##1 mem_dq_oe == 2'b00)
    else $error("terminate did not end read at latency two");
  a_term_lat3: assert property (
    trm && lat == LAT_3 && $past(rd) |-> ##2 mem_dq_oe == 2'b11 ##1 mem_dq_oe == 2'b00)
    else $error("terminate did not end read at latency three");
  a_burst_four: assert property (
    rd && address_pins[AUTO_PRE_BIT] && lat == LAT_2 && bl == 3'h2 |->
      ##2 (mem_dq_oe == 2'b11) [*4] ##1 mem_dq_oe == 2'b00)
    else $error("four-element read burst not one element per clock");
  a_write_float: assert property (
    wr |=> mem_dq_oe == 2'b00)
    else $error("data pins driven after write");
  a_mask_output: assert property (
    byte_mask != 2'b00 |-> ##2 (mem_dq_oe & $past(byte_mask, 2)) == 2'b00)
    else $error("masked byte still driven");
  a_mask_lead: assert property (
    wr |-> byte_mask == 2'b00 && $past(byte_mask) == 2'b11 && $past(byte_mask, 3) == 2'b11)
    else $error("mask not raised ahead of write or not low at write");
  a_mode_normal: assert property (
    md |-> address_pins[8:7] == 2'b00)
    else $error("mode word selects a test mode");
  a_mode_latency: assert property (
    md |-> address_pins[6:4] == LAT_2 || address_pins[6:4] == LAT_3)
    else $error("mode word latency not allowed");
  a_column_open: assert property (
    rd || wr |-> open_banks[bank])
    else $error("column access to a closed bank");
  a_act_closed: assert property (
    act |-> !open_banks[bank] ##1 !(act && bank == $past(bank)))
    else $error("activate to a bank with an open row");
endmodule

// ==== tb/tb_top.sv ====
// Purpose: drives the controller over apb against the device end
// Assumes: 25 MHz pclk, reset held three cycles
// Notes: written data is read back per bank and column at both latencies
`timescale 1ns/1ps
module tb_top;
  import sdram_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd, d0, d1;
  logic [3:0] banks_open;
  int mismatches, num_checks;

  sdram_link_if link ();
  sdram_device_end sdram_device_end_i (.pclk(pclk), .presetn(presetn), .link(link),
    .banks_open(banks_open));
  sdram_controller_end sdram_controller_end_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  sdram_link_asserts sdram_link_asserts_i (.pclk(pclk), .presetn(presetn),
    .chip_select_n(link.chip_select_n), .ras_n(link.ras_n), .cas_n(link.cas_n),
    .we_n(link.we_n), .bank_select_low(link.bank_select_low),
    .bank_select_high(link.bank_select_high), .address_pins(link.address_pins),
    .byte_mask(link.byte_mask), .mem_dq_oe(link.mem_dq_oe));

  task automatic give_verdict();
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask

  // request held until pready is seen high at a rising edge, data taken there
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {24'h000000, a};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) chk(32'h0000_0000, 32'h0000_0001);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic op(input logic [2:0] code, input logic [31:0] addr);
    int n;
    apb(1'b1, REG_ADDR, addr);
    apb(1'b1, REG_CMD, {29'h00000000, code});
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0000_0000);
      n++;
    end while (rd[0] !== 1'b0 && n < 40);
    if (n >= 40) chk(32'h0000_0000, 32'h0000_0001);
  endtask

  task automatic chk_banks(input logic [3:0] exp);
    @(negedge pclk);
    chk({28'h0000000, banks_open}, {28'h0000000, exp});
    @(posedge pclk);
  endtask

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    $display("unexpected at %0t: run did not finish", $time);
    mismatches++;
    give_verdict();
  end

  initial begin
    mismatches = 0;
    num_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk({31'h00000000, err}, 32'h0000_0001);
    // test-mode bits and a bad latency must both be refused
    op(OP_MODE, 32'h0000_00A0);
    chk(rd, 32'h0000_0002);
    apb(1'b1, REG_STATUS, 32'h0000_0002);
    op(OP_MODE, 32'h0000_0040);
    chk(rd, 32'h0000_0002);
    apb(1'b1, REG_STATUS, 32'h0000_0002);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    for (int li = 0; li < 2; li++) begin
      d0 = 32'h0000_A5C3 ^ li;
      d1 = 32'h0000_3C5A ^ li;
      op(OP_MODE, (li == 0) ? 32'h0000_0020 : 32'h0000_0030);
      op(OP_ACT, 32'h0000_0001);
      op(OP_ACT, 32'h0000_2003);
      chk_banks(4'h5);
      apb(1'b1, REG_WDATA, d0);
      op(OP_WRITE, 32'h0000_0005);
      apb(1'b1, REG_WDATA, d1);
      op(OP_WRITE, 32'h0000_2085);
      op(OP_READ, 32'h0000_0005);
      apb(1'b0, REG_RDATA, 32'h0000_0000);
      chk(rd, d0);
      op(OP_READ, 32'h0000_2485);
      apb(1'b0, REG_RDATA, 32'h0000_0000);
      chk(rd, d1);
      chk_banks(4'h1);
      op(OP_PRE, 32'h0000_0400);
      chk_banks(4'h0);
    end
    // an unused op code is refused like a bad mode word
    op(3'h5, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    apb(1'b1, REG_STATUS, 32'h0000_0002);
    // four-element bursts: cut by terminate, then run out with auto-precharge
    op(OP_MODE, 32'h0000_0022);
    apb(1'b0, REG_MODE, 32'h0000_0000);
    chk(rd, 32'h0000_0022);
    op(OP_ACT, 32'h0000_0001);
    op(OP_READ, 32'h0000_0005);
    apb(1'b0, REG_RDATA, 32'h0000_0000);
    chk(rd, d0);
    op(OP_READ, 32'h0000_0405);
    apb(1'b0, REG_RDATA, 32'h0000_0000);
    chk(rd, d0);
    chk_banks(4'h0);
    give_verdict();
  end
endmodule
